// ### shared/epir_pkg.sv
// Package: register map, field positions and reset values of the pin request block
package epir_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [11:0] EPIR_OFS_STATUS_CONTROL = 12'h000;
   localparam int          EPIR_REG_WIDTH          = 8;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int EPIR_BIT_PULL_DEVICE_DISABLE      = 6;
   localparam int EPIR_BIT_POLARITY_SELECT          = 5;
   localparam int EPIR_BIT_PIN_FUNCTION_ENABLE      = 4;
   localparam int EPIR_BIT_REQUEST_FLAG             = 3;
   localparam int EPIR_BIT_REQUEST_ACKNOWLEDGE      = 2;
   localparam int EPIR_BIT_REQUEST_INTERRUPT_ENABLE = 1;
   localparam int EPIR_BIT_DETECTION_MODE_SELECT    = 0;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] EPIR_RESET_CONTROL = 8'h00;
   localparam int         EPIR_SYNC_STAGES   = 2;
   // AHB encodings
   localparam logic [1:0] EPIR_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] EPIR_HTRANS_SEQ    = 2'h3;
endpackage : epir_pkg

// ### shared/epir_cfg_if.sv
// Interface: configuration and status between bus slave and pin detector
`timescale 1ns/1ps
interface epir_cfg_if;
   logic pull_device_disable;
   logic polarity_select;
   logic pin_function_enable;
   logic detection_mode_select;
   logic ack_pulse;
   logic request_flag;
   modport regs (
      output pull_device_disable,
      output polarity_select,
      output pin_function_enable,
      output detection_mode_select,
      output ack_pulse,
      input  request_flag
   );
   modport det (
      input  pull_device_disable,
      input  polarity_select,
      input  pin_function_enable,
      input  detection_mode_select,
      input  ack_pulse,
      output request_flag
   );
endinterface : epir_cfg_if

// ### rtl/epir_sync.sv
// Two-stage synchroniser for the interrupt pin
`timescale 1ns/1ps
module epir_sync #(
   parameter int STAGES = 2
) (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic d,
   output logic      q
);
   logic [STAGES-1:0] chain;
   logic [STAGES-1:0] next_chain;

   always_comb begin
      next_chain = {chain[STAGES-2:0], d};
   end

   // Reset value is high: idle level of a pulled-up pin
   always_ff @(posedge clk) begin
      if (!rstn) begin
         chain <= '1;
      end else begin
         chain <= next_chain;
      end
   end

   assign q = chain[STAGES-1];
endmodule : epir_sync

// ### rtl/epir_detect.sv
// Edge and level detector with the request flag
`timescale 1ns/1ps
module epir_detect (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic pin_sync,
   epir_cfg_if.det   cfg
);
   logic prev;
   logic flag;
   logic next_prev;
   logic next_flag;
   logic active_lvl;
   logic edge_hit;
   logic event_hit;

   always_comb begin
      active_lvl = (pin_sync == cfg.polarity_select);
      edge_hit   = (prev != pin_sync) && active_lvl;
      event_hit  = cfg.pin_function_enable
                   && (edge_hit || (cfg.detection_mode_select && active_lvl));
      next_prev  = pin_sync;
      next_flag  = flag;
      if (!cfg.pin_function_enable) begin
         next_flag = 1'b0;
      end else if (event_hit) begin
         // Event ahead of acknowledge: an asserted level survives the clear
         next_flag = 1'b1;
      end else if (cfg.ack_pulse) begin
         next_flag = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         prev <= 1'b1;
         flag <= 1'b0;
      end else begin
         prev <= next_prev;
         flag <= next_flag;
      end
   end

   assign cfg.request_flag = flag;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_level_holds;
      @(posedge clk) disable iff (!rstn)
         (cfg.pin_function_enable && cfg.detection_mode_select && active_lvl)
         |=> flag;
   endproperty
   a_level_holds: assert property (p_level_holds)
      else $error("flag cleared while level asserted");

   property p_edge_sets;
      @(posedge clk) disable iff (!rstn)
         (cfg.pin_function_enable && $changed(pin_sync)
          && pin_sync == cfg.polarity_select) |=> flag;
   endproperty
   a_edge_sets: assert property (p_edge_sets)
      else $error("active edge did not set flag");

   property p_ack_clears;
      @(posedge clk) disable iff (!rstn)
         (cfg.ack_pulse && !event_hit) |=> !flag;
   endproperty
   a_ack_clears: assert property (p_ack_clears)
      else $error("acknowledge did not clear flag");

   property p_no_spurious;
      @(posedge clk) disable iff (!rstn)
         (!flag && !event_hit) |=> !flag;
   endproperty
   a_no_spurious: assert property (p_no_spurious)
      else $error("flag set without event");

   property p_disabled;
      @(posedge clk) disable iff (!rstn)
         !cfg.pin_function_enable |=> !flag;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("flag set while pin disabled");

   property p_inactive_edge;
      @(posedge clk) disable iff (!rstn)
         (!flag && !cfg.detection_mode_select && $changed(pin_sync)
          && pin_sync != cfg.polarity_select) |=> !flag;
   endproperty
   a_inactive_edge: assert property (p_inactive_edge)
      else $error("wrong polarity edge set flag");
endmodule : epir_detect

// ### rtl/epir_top.sv
// Top: AHB-Lite slave and pin request status and control register
// Operation
// - With pin enabled, pull device off when disable bit is one, else on.
// - Polarity bit zero selects falling/low; one selects rising/high.
// - Pin-enable bit, readable and writable, gates the whole request function.
// - Read-only flag sets on a qualifying pin event, reads pending state.
// - Writing one to acknowledge clears the flag; acknowledge reads zero.
// - In edge-and-level mode acknowledge cannot clear while level is asserted.
// - Interrupt output follows the flag when interrupt enable is one.
// - Mode bit zero is edge-only; one adds active level detection.
`timescale 1ns/1ps
module epir_top (
   input  wire logic        CLK,
   input  wire logic        RSTN,
   input  wire logic        HSEL,
   input  wire logic [11:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        IRQ_PIN,
   output logic             PULL_ENABLE,
   output logic             PULL_DOWN,
   output logic             IRQ_REQUEST
);
   // ----------------------------------------------------------------
   // Bus address phase capture
   // ----------------------------------------------------------------
   logic       wr_pend;
   logic       next_wr_pend;
   logic       hit_phase;
   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   logic       ack_pulse;
   logic [31:0] next_rdata;
   logic       pin_sync;

   epir_cfg_if cfg ();

   always_comb begin
      hit_phase = HSEL && HREADY && (HTRANS == epir_pkg::EPIR_HTRANS_NONSEQ
                  || HTRANS == epir_pkg::EPIR_HTRANS_SEQ)
                  && (HADDR[11:2] == epir_pkg::EPIR_OFS_STATUS_CONTROL[11:2]);
      next_wr_pend = hit_phase && HWRITE;
      next_rdata = 32'h0000_0000;
      if (hit_phase && !HWRITE) begin
         // Acknowledge bit always reads zero
         next_rdata[7:0] = ctrl;
         next_rdata[epir_pkg::EPIR_BIT_REQUEST_FLAG] = cfg.request_flag;
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always_comb begin
      next_ctrl = ctrl;
      ack_pulse = 1'b0;
      if (wr_pend) begin
         next_ctrl = HWDATA[7:0];
         // Flag and acknowledge are not stored here
         next_ctrl[epir_pkg::EPIR_BIT_REQUEST_FLAG]        = 1'b0;
         next_ctrl[epir_pkg::EPIR_BIT_REQUEST_ACKNOWLEDGE] = 1'b0;
         next_ctrl[7] = 1'b0;
         ack_pulse = HWDATA[epir_pkg::EPIR_BIT_REQUEST_ACKNOWLEDGE];
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         wr_pend <= 1'b0;
         ctrl    <= epir_pkg::EPIR_RESET_CONTROL;
         HRDATA  <= 32'h0000_0000;
      end else begin
         wr_pend <= next_wr_pend;
         ctrl    <= next_ctrl;
         HRDATA  <= next_rdata;
      end
   end

   // Zero wait states; every access answers OKAY
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

   assign cfg.pull_device_disable   = ctrl[epir_pkg::EPIR_BIT_PULL_DEVICE_DISABLE];
   assign cfg.polarity_select       = ctrl[epir_pkg::EPIR_BIT_POLARITY_SELECT];
   assign cfg.pin_function_enable   = ctrl[epir_pkg::EPIR_BIT_PIN_FUNCTION_ENABLE];
   assign cfg.detection_mode_select = ctrl[epir_pkg::EPIR_BIT_DETECTION_MODE_SELECT];
   assign cfg.ack_pulse             = ack_pulse;

   // ----------------------------------------------------------------
   // Pin path
   // ----------------------------------------------------------------
   epir_sync #(
      .STAGES (epir_pkg::EPIR_SYNC_STAGES)
   ) u_sync (
      .clk  (CLK),
      .rstn (RSTN),
      .d    (IRQ_PIN),
      .q    (pin_sync)
   );

   epir_detect u_detect (
      .clk      (CLK),
      .rstn     (RSTN),
      .pin_sync (pin_sync),
      .cfg      (cfg.det)
   );

   // Pull device only while the pin function owns the pin
   assign PULL_ENABLE = cfg.pin_function_enable && !cfg.pull_device_disable;
   assign PULL_DOWN   = PULL_ENABLE && cfg.polarity_select;
   assign IRQ_REQUEST = cfg.request_flag
                        && ctrl[epir_pkg::EPIR_BIT_REQUEST_INTERRUPT_ENABLE];

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_irq_follows;
      @(posedge CLK) disable iff (!RSTN)
         IRQ_REQUEST == (cfg.request_flag
                         && ctrl[epir_pkg::EPIR_BIT_REQUEST_INTERRUPT_ENABLE]);
   endproperty
   a_irq_follows: assert property (p_irq_follows)
      else $error("interrupt request not tied to flag");

   property p_pull;
      @(posedge CLK) disable iff (!RSTN)
         (wr_pend && HWDATA[epir_pkg::EPIR_BIT_PIN_FUNCTION_ENABLE]
          && !HWDATA[epir_pkg::EPIR_BIT_PULL_DEVICE_DISABLE])
         |=> PULL_ENABLE && (PULL_DOWN == $past(HWDATA[epir_pkg::EPIR_BIT_POLARITY_SELECT]));
   endproperty
   a_pull: assert property (p_pull)
      else $error("pull device not configured as written");

   property p_pull_off;
      @(posedge CLK) disable iff (!RSTN)
         (wr_pend && HWDATA[epir_pkg::EPIR_BIT_PULL_DEVICE_DISABLE]) |=> !PULL_ENABLE;
   endproperty
   a_pull_off: assert property (p_pull_off)
      else $error("pull device on while disabled");

   property p_ack_reads_zero;
      @(posedge CLK) disable iff (!RSTN)
         1'b1 |=> !HRDATA[epir_pkg::EPIR_BIT_REQUEST_ACKNOWLEDGE] && HRDATA[31:8] == 24'h000000;
   endproperty
   a_ack_reads_zero: assert property (p_ack_reads_zero)
      else $error("acknowledge bit read as one");
endmodule : epir_top

// ### bench/epir_pin_src.sv
// Partner model: external source driving the interrupt request pin
`timescale 1ns/1ps
module epir_pin_src (
   input  wire logic clk,
   input  wire logic drive_en,
   input  wire logic drive_val,
   input  wire logic pull_en,
   input  wire logic pull_dn,
   output logic      pin
);
   // ----------------------------------------------------------------
   // Pin level
   // ----------------------------------------------------------------
   logic float_val = 1'b0;
   // Undriven and unpulled pin wanders each cycle, never holds a level
   // Plain clocked process: the declaration already gives the start value
   always @(posedge clk) begin
      float_val <= ~float_val;
   end
   assign pin = drive_en ? drive_val : (pull_en ? ~pull_dn : float_val);
endmodule : epir_pin_src

// ### bench/test_external_pin_interrupt_request.sv
// Testbench: register and pin scenarios of the pin request block
`timescale 1ns/1ps
module test_external_pin_interrupt_request;
   logic        CLK     = 1'b0;
   logic        RSTN    = 1'b0;
   logic        HSEL    = 1'b0;
   logic        HWRITE  = 1'b0;
   logic [11:0] HADDR   = 12'h000;
   logic [1:0]  HTRANS  = 2'h0;
   logic [31:0] HWDATA  = 32'h00000000;
   logic [31:0] HRDATA;
   logic        HREADY;
   logic        HREADYOUT;
   logic        HRESP;
   logic        IRQ_PIN;
   logic        PULL_ENABLE;
   logic        PULL_DOWN;
   logic        IRQ_REQUEST;
   logic        drv_en  = 1'b1;
   logic        drv_val = 1'b1;
   logic [31:0] rd;
   logic [23:0] r;
   int          error_cnt = 0;
   int          compares  = 0;
   int          cycles    = 0;
   // Row: write value, pin (0 low, 1 high, 2 released), read value, {irq, pull_en, pull_dn}
   localparam logic [23:0] ROWS [18] = '{
      24'h02_2_02_0, 24'h02_1_02_0, 24'h12_1_12_2, 24'h12_2_12_2, 24'h12_0_1A_6,
      24'h12_0_1A_6, 24'h16_0_12_2, 24'h10_1_10_2, 24'h10_0_18_2, 24'h34_0_30_3,
      24'h30_2_30_3, 24'h30_1_38_3, 24'h74_1_70_0, 24'h75_1_79_0, 24'h77_1_7B_4,
      24'h77_0_7B_4, 24'h77_0_73_0, 24'h00_1_00_0};
   assign HREADY = HREADYOUT;

   epir_top epir_top_i (
      .CLK         (CLK),
      .RSTN        (RSTN),
      .HSEL        (HSEL),
      .HADDR       (HADDR),
      .HTRANS      (HTRANS),
      .HWRITE      (HWRITE),
      .HSIZE       (3'h2),
      .HWDATA      (HWDATA),
      .HREADY      (HREADY),
      .HRDATA      (HRDATA),
      .HREADYOUT   (HREADYOUT),
      .HRESP       (HRESP),
      .IRQ_PIN     (IRQ_PIN),
      .PULL_ENABLE (PULL_ENABLE),
      .PULL_DOWN   (PULL_DOWN),
      .IRQ_REQUEST (IRQ_REQUEST)
   );
   epir_pin_src epir_pin_src_i (
      .clk       (CLK),
      .drive_en  (drv_en),
      .drive_val (drv_val),
      .pull_en   (PULL_ENABLE),
      .pull_dn   (PULL_DOWN),
      .pin       (IRQ_PIN)
   );
   // ----------------------------------------------------------------
   // Clock, timeout and report
   // ----------------------------------------------------------------
   initial begin
      forever #25 CLK = ~CLK;
   end
   // Run needs about 200 cycles; ceiling leaves ample slack
   always @(posedge CLK) begin
      cycles <= cycles + 1;
      if (cycles == 1500) begin
         error_cnt++;
         summarize();
      end
   end
   task summarize;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : summarize
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // ----------------------------------------------------------------
   // AHB-Lite single word transfer
   // ----------------------------------------------------------------
   task bus(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q);
      @(posedge CLK);
      HSEL   <= 1'b1;
      HTRANS <= epir_pkg::EPIR_HTRANS_NONSEQ;
      HADDR  <= a;
      HWRITE <= wr;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HSEL   <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= {24'h000000, d};
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      q = HRDATA;
   endtask : bus
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge CLK);
      RSTN <= 1'b1;
      chk("pull_en", 32'h00000000, {31'h0, PULL_ENABLE});
      chk("irq", 32'h00000000, {31'h0, IRQ_REQUEST});
      bus(1'b0, 12'h000, 8'h00, rd);
      chk("reset", 32'h00000000, rd);
      bus(1'b1, 12'h004, 8'hFF, rd);
      bus(1'b0, 12'h000, 8'h00, rd);
      chk("unmapped_wr", 32'h00000000, rd);
      bus(1'b0, 12'h004, 8'h00, rd);
      chk("unmapped", 32'h00000000, rd);
      chk("hresp", 32'h00000000, {31'h0, HRESP});
      chk("hready", 32'h00000001, {31'h0, HREADYOUT});
      for (int i = 0; i < 18; i++) begin
         r = ROWS[i];
         bus(1'b1, 12'h000, r[23:16], rd);
         drv_en  <= (r[15:12] != 4'h2);
         drv_val <= r[12];
         // Flag lands three edges after the pin moves
         repeat (4) @(posedge CLK);
         bus(1'b0, 12'h000, 8'h00, rd);
         chk("reg", {24'h000000, r[11:4]}, rd);
         chk("irq", {31'h0, r[2]}, {31'h0, IRQ_REQUEST});
         chk("pull_en", {31'h0, r[1]}, {31'h0, PULL_ENABLE});
         chk("pull_dn", {31'h0, r[0]}, {31'h0, PULL_DOWN});
      end
      summarize();
   end
endmodule : test_external_pin_interrupt_request
